/* File: core/pvsr_pkg.sv */
// register map, field layout and state types of the pll and oscillator status bank
package pvsr_pkg;

  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // byte offsets of the registers
  localparam logic [ADDR_W-1:0] OFS_PLL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CAL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TRIM = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_ANA = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_CFG = 8'h10;
  localparam logic [ADDR_W-1:0] WORD_MASK = 8'hFC;

  // pll_state fields
  localparam int PLL_LOCK_BIT = 0;
  localparam int PLL_RAIL_LOW_BIT = 1;
  localparam int PLL_RAIL_HIGH_BIT = 2;

  // oscillator_calibration_state fields
  localparam int CAL_BAND_LSB = 0;
  localparam int CAL_BAND_W = 6;
  localparam int CAL_DONE_BIT = 6;
  localparam int CAL_FAIL_BIT = 7;

  // oscillator_coarse_tune_state fields
  localparam int TRIM_LSB = 0;
  localparam int TRIM_W = 2;
  localparam logic [TRIM_W-1:0] TRIM_RST = 2'h1;

  // analog_spare_and_supply_detect fields
  localparam int BANK_LSB = 0;
  localparam int BANK_N = 7;
  localparam int SPARE_LSB = 7;
  localparam int SPARE_N = 9;

  // trim configuration register fields
  localparam int CFG_TRIM_LSB = 0;
  localparam int CFG_CAL_EN_BIT = 4;
  localparam logic [TRIM_W-1:0] CFG_TRIM_RST = 2'h1;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // register selected by an address
  typedef enum {
    SEL_PLL,
    SEL_CAL,
    SEL_TRIM,
    SEL_ANA,
    SEL_CFG,
    SEL_NONE
  } pvsr_sel_t;

  // inputs coming from analog and calibration logic
  typedef struct packed {
    logic [SPARE_N-1:0] spare;
    logic [BANK_N-1:0] bank;
    logic [TRIM_W-1:0] cal_trim;
    logic [CAL_BAND_W-1:0] cal_band;
    logic cal_fail;
    logic cal_done;
    logic rail_low;
    logic rail_high;
    logic lock;
  } pvsr_ana_t;

  // whole state of the block
  typedef struct packed {
    pvsr_ana_t s1;
    pvsr_ana_t s2;
    pvsr_ana_t stat;
    logic [TRIM_W-1:0] trim;
    logic [TRIM_W-1:0] cfg_trim;
    logic cfg_cal_en;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] aw_addr;
    logic [DATA_W-1:0] w_data;
    logic [DATA_W/8-1:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } pvsr_state_t;

endpackage

/* File: core/pvsr_status_regs.sv */
// axi4-lite status bank for pll lock, vco calibration, coarse trim and supply detect
`timescale 1ns/1ps
module pvsr_status_regs (
  input wire logic aclk, // 200 MHz clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [pvsr_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic [2:0] s_axi_awprot, // write protection, unused
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [pvsr_pkg::DATA_W-1:0] s_axi_wdata, // write data
  input wire logic [pvsr_pkg::DATA_W/8-1:0] s_axi_wstrb, // write byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [pvsr_pkg::ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic [2:0] s_axi_arprot, // read protection, unused
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [pvsr_pkg::DATA_W-1:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic pll_locked, // analog pll lock level
  input wire logic pll_rail_high, // pll control at upper rail
  input wire logic pll_rail_low, // pll control at lower rail
  input wire logic cal_done, // vco band calibration finished
  input wire logic cal_failed, // vco band calibration failed
  input wire logic [pvsr_pkg::CAL_BAND_W-1:0] cal_band, // band chosen by calibration
  input wire logic [pvsr_pkg::TRIM_W-1:0] cal_trim, // trim chosen by calibration
  input wire logic [pvsr_pkg::BANK_N-1:0] bank_supply_detect, // per bank regulator detect
  input wire logic [pvsr_pkg::SPARE_N-1:0] analog_spare // spare analog bits
);
  import pvsr_pkg::*;

  pvsr_state_t st_reg;
  pvsr_state_t st_next;
  pvsr_ana_t pins;

  // map an address to a register, low two bits ignored
  function automatic pvsr_sel_t decode(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] a;
    a = addr & WORD_MASK;
    if (a == OFS_PLL) begin
      return SEL_PLL;
    end else if (a == OFS_CAL) begin
      return SEL_CAL;
    end else if (a == OFS_TRIM) begin
      return SEL_TRIM;
    end else if (a == OFS_ANA) begin
      return SEL_ANA;
    end else if (a == OFS_CFG) begin
      return SEL_CFG;
    end
    return SEL_NONE;
  endfunction

  // value of the state after reset
  function automatic pvsr_state_t reset_state();
    pvsr_state_t r;
    r = '0;
    r.trim = TRIM_RST;
    r.cfg_trim = CFG_TRIM_RST;
    return r;
  endfunction

  // gather the analog inputs into one bundle
  always_comb begin
    pins.lock = pll_locked;
    pins.rail_high = pll_rail_high;
    pins.rail_low = pll_rail_low;
    pins.cal_done = cal_done;
    pins.cal_fail = cal_failed;
    pins.cal_band = cal_band;
    pins.cal_trim = cal_trim;
    pins.bank = bank_supply_detect;
    pins.spare = analog_spare;
  end

  // next state: synchronisers, status capture, write and read channels
  always_comb begin
    logic [DATA_W-1:0] word;
    pvsr_sel_t wsel;
    pvsr_sel_t rsel;
    word = '0;
    st_next = st_reg;
    wsel = decode(st_reg.aw_addr);
    rsel = decode(s_axi_araddr);

    // two flops, then a status capture read by the bus
    st_next.s1 = pins;
    st_next.s2 = st_reg.s1;
    st_next.stat = st_reg.s2;

    // coarse trim source follows the calibration enable
    if (st_reg.cfg_cal_en) begin
      st_next.trim = st_reg.s2.cal_trim;
    end else begin
      st_next.trim = st_reg.cfg_trim;
    end

    // write response handshake
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end

    // write address and data taken in either order
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_got = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_got = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end

    // perform the write once both halves are held
    if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      unique case (wsel)
        SEL_CFG: begin
          if (st_reg.w_strb[0]) begin
            st_next.cfg_trim = st_reg.w_data[CFG_TRIM_LSB +: TRIM_W];
            st_next.cfg_cal_en = st_reg.w_data[CFG_CAL_EN_BIT];
          end
        end
        SEL_PLL, SEL_CAL, SEL_TRIM, SEL_ANA: begin
          st_next.bresp = RESP_OKAY; // status is read-only, data dropped
        end
        SEL_NONE: begin
          st_next.bresp = RESP_SLVERR;
        end
      endcase
    end
    st_next.awready = !st_next.aw_got && !st_next.bvalid;
    st_next.wready = !st_next.w_got && !st_next.bvalid;

    // read data handshake
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end

    // read address taken, word assembled from the captured status, the trim register or the configuration
    if (s_axi_arvalid && st_reg.arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = RESP_OKAY;
      unique case (rsel)
        SEL_PLL: begin
          word[PLL_LOCK_BIT] = st_reg.stat.lock;
          word[PLL_RAIL_LOW_BIT] = st_reg.stat.rail_low;
          word[PLL_RAIL_HIGH_BIT] = st_reg.stat.rail_high;
        end
        SEL_CAL: begin
          word[CAL_BAND_LSB +: CAL_BAND_W] = st_reg.stat.cal_band;
          word[CAL_DONE_BIT] = st_reg.stat.cal_done;
          word[CAL_FAIL_BIT] = st_reg.stat.cal_fail;
        end
        SEL_TRIM: begin
          word[TRIM_LSB +: TRIM_W] = st_reg.trim;
        end
        SEL_ANA: begin
          word[BANK_LSB +: BANK_N] = st_reg.stat.bank;
          word[SPARE_LSB +: SPARE_N] = st_reg.stat.spare;
        end
        SEL_CFG: begin
          word[CFG_TRIM_LSB +: TRIM_W] = st_reg.cfg_trim;
          word[CFG_CAL_EN_BIT] = st_reg.cfg_cal_en;
        end
        SEL_NONE: begin
          st_next.rresp = RESP_SLVERR;
        end
      endcase
      st_next.rdata = word; // unlisted bits stay zero
    end
    st_next.arready = !st_next.rvalid;
  end

  // single register stage for all state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= reset_state();
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state flops
  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;

endmodule

/* File: tb/pvsr_status_regs_bench.sv */
// self-checking bench for the status bank
`timescale 1ns/1ps
module pvsr_status_regs_bench;
  import pvsr_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cen;
  logic pll_locked, pll_rail_high, pll_rail_low, cal_done, cal_failed;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, v, seed;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, cal_trim, ctrim;
  logic [5:0] cal_band;
  logic [6:0] bank_supply_detect;
  logic [8:0] analog_spare;
  logic [28:0] ana;
  int error_cnt, comparisons;
  pvsr_status_regs uut (.*);
  assign {pll_locked, pll_rail_high, pll_rail_low, cal_done, cal_failed, cal_band, cal_trim,
    bank_supply_detect, analog_spare} = ana;
  // clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // xorshift source
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // expected word of a status register
  function automatic logic [31:0] exp_word(input logic [7:0] a);
    case (a)
      OFS_PLL: return {29'h0, pll_rail_high, pll_rail_low, pll_locked};
      OFS_CAL: return {24'h0, cal_failed, cal_done, cal_band};
      OFS_TRIM: return {30'h0, cen ? cal_trim : ctrim};
      default: return {16'h0, analog_spare, bank_supply_detect};
    endcase
  endfunction
  task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_resp(input string n, input logic [1:0] e, input logic [1:0] g);
    chk_word(n, {30'h0, e}, {30'h0, g});
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // one read, ready stalled at random
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    logic dn;
    @(posedge aclk);
    dn = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= xs() > 32'h7FFFFFFF;
    while (!dn) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      dn = s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= !dn;
    end
  endtask
  // one write, response ready stalled at random
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [1:0] rs);
    logic dn;
    @(posedge aclk);
    dn = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= xs() > 32'h7FFFFFFF;
    while (!dn) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      dn = s_axi_bvalid && s_axi_bready;
      rs = s_axi_bresp;
      s_axi_bready <= !dn;
    end
  endtask
  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    ctrim = TRIM_RST;
    cen = 1'b0;
  endtask
  // read all four status words, low address bits scrambled
  task automatic check_all(input string tn);
    for (int i = 0; i < 4; i++) begin
      rd(8'(5 * i), v, r);
      chk_word("status word", exp_word(8'(5 * i) & WORD_MASK), v);
      chk_resp("status read resp", RESP_OKAY, r);
    end
    $display("test %s done", tn);
  endtask
  // watchdog
  initial begin
    #100000;
    error_cnt++;
    $display("ERROR watchdog expected finish seen timeout");
    give_verdict();
  end
  initial begin
    {error_cnt, comparisons, seed, aresetn} = {32'h0, 32'h0, 32'h11FFE, 1'b0};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, s_axi_awprot, s_axi_arprot} = 58'h0;
    ana = 29'h0;
    do_reset();
    check_all("reset values");
    for (int k = 0; k < 24; k++) begin
      @(posedge aclk);
      ana <= 29'(xs());
      repeat (8) @(posedge aclk);
      v = xs();
      wr(OFS_CFG, v, 4'(k), r);
      if (k % 2 == 1) {ctrim, cen} = {v[1:0], v[4]};
      chk_resp("cfg write resp", RESP_OKAY, r);
      check_all("random status");
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'(4 * i), 32'hFFFFFFFF, 4'hF, r);
      chk_resp("status write resp", RESP_OKAY, r);
    end
    wr(8'h40, 32'h1, 4'hF, r);
    chk_resp("unmapped write resp", RESP_SLVERR, r);
    rd(8'h40, v, r);
    chk_resp("unmapped read resp", RESP_SLVERR, r);
    chk_word("unmapped read data", 32'h0, v);
    check_all("writes ignored");
    wr(OFS_CFG, 32'h13, 4'hF, r);
    ana <= 29'h1FFFFFFF;
    do_reset();
    // first read after release still sees cleared status despite live pins
    rd(OFS_PLL, v, r);
    chk_word("pll right after reset", 32'h0, v);
    repeat (8) @(posedge aclk);
    check_all("second reset");
    give_verdict();
  end
endmodule

/* File: tb/pvsr_status_regs_props.sv */
// read path and reset checker for the status bank
`timescale 1ns/1ps
module pvsr_status_regs_props
  import pvsr_pkg::*;
(
  input wire logic aclk, aresetn, // clock, reset
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, // read handshake
  input wire logic [DATA_W-1:0] s_axi_rdata, // read data
  input wire logic [1:0] s_axi_rresp, s_axi_bresp, // responses
  input wire logic s_axi_bvalid, s_axi_bready, // write response handshake
  input wire logic pll_locked, pll_rail_high, pll_rail_low, cal_done, cal_failed, // levels
  input wire logic [CAL_BAND_W-1:0] cal_band, // band
  input wire logic [BANK_N-1:0] bank_supply_detect, // banks
  input wire logic [SPARE_N-1:0] analog_spare // spares
);
  logic [26:0] cur, ins_reg;
  logic [2:0] calm_reg;
  logic take;
  // status inputs gathered, read accept strobe
  assign cur = {pll_locked, pll_rail_high, pll_rail_low, cal_done, cal_failed, cal_band,
    bank_supply_detect, analog_spare};
  assign take = s_axi_arvalid && s_axi_arready;
  // cycles since status inputs last moved, so sync latency is covered
  always_ff @(posedge aclk) begin
    ins_reg <= cur;
    if (!aresetn || ins_reg != cur) calm_reg <= 3'h0;
    else if (calm_reg != 3'h7) calm_reg <= calm_reg + 3'h1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_pll; take && calm_reg > 3'h4 && s_axi_araddr[7:2] == OFS_PLL[7:2]
    |=> s_axi_rdata == {29'h0, pll_rail_high, pll_rail_low, pll_locked}; endproperty
  a_pll: assert property (p_pll) else $error("pll word wrong");
  property p_cal; take && calm_reg > 3'h4 && s_axi_araddr[7:2] == OFS_CAL[7:2]
    |=> s_axi_rdata == {24'h0, cal_failed, cal_done, cal_band}; endproperty
  a_cal: assert property (p_cal) else $error("calibration word wrong");
  property p_ana; take && calm_reg > 3'h4 && s_axi_araddr[7:2] == OFS_ANA[7:2]
    |=> s_axi_rdata == {16'h0, analog_spare, bank_supply_detect}; endproperty
  a_ana: assert property (p_ana) else $error("analog word wrong");
  property p_trim; take && s_axi_araddr[7:2] == OFS_TRIM[7:2] |=> s_axi_rdata[31:2] == 30'h0;
  endproperty
  a_trim: assert property (p_trim) else $error("trim reserved bits set");
  property p_bad; take && s_axi_araddr > 8'h13
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0; endproperty
  a_bad: assert property (p_bad) else $error("unmapped read answered");
  property p_ok; take && s_axi_araddr < 8'h10 |=> s_axi_rvalid && s_axi_rresp == RESP_OKAY;
  endproperty
  a_ok: assert property (p_ok) else $error("status read refused");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rst; disable iff (1'b0) !aresetn
    |=> !s_axi_rvalid && !s_axi_bvalid && s_axi_rdata == 32'h0; endproperty
  a_rst: assert property (p_rst) else $error("outputs live in reset");
endmodule
bind pvsr_status_regs pvsr_status_regs_props chk (.*);
